// ===== hw/drt_map.svh
// Register offsets, field positions and reset values of the refresh/timing block
`ifndef DRT_MAP_SVH
`define DRT_MAP_SVH

// Wishbone register offsets (byte addresses)
`define DRT_ADR_W 8
`define DRT_OFS_BANKCFG 8'h00
`define DRT_OFS_REFCTL 8'h04
`define DRT_OFS_TIMING 8'h08
`define DRT_OFS_STATUS 8'h0c

// Bank configuration: timing write unlock
`define DRT_UNLOCK_B 15
`define DRT_BANKCFG_MASK 32'h00008000
`define DRT_BANKCFG_RST 32'h00000000

// Refresh control fields
`define DRT_SRREQ_B 31
`define DRT_CLKSTOP_B 30
`define DRT_IVL_F 15:0
`define DRT_IVL_MIN 16'h0100
`define DRT_REFCTL_MASK 32'hc000ffff
`define DRT_REFCTL_RST 32'h00000400

// Command timing fields
`define DRT_TRFC_F 31:25
`define DRT_TRP_F 24:22
`define DRT_TRCD_F 21:19
`define DRT_TWR_F 18:16
`define DRT_TRAS_F 15:11
`define DRT_TRC_F 10:6
`define DRT_TRRD_F 5:3
`define DRT_TWTR_F 1:0
`define DRT_TIMING_MASK 32'hfffffffb
`define DRT_TIMING_RST 32'h356b4b9b

// Status bits
`define DRT_ST_INSR_B 0
`define DRT_ST_CLKRUN_B 1
`define DRT_ST_REFPEND_B 2

// Spacing timer indices
`define DRT_TM_RFC 0
`define DRT_TM_RP 1
`define DRT_TM_RCD 2
`define DRT_TM_WR 3
`define DRT_TM_RAS 4
`define DRT_TM_RC 5
`define DRT_TM_RRD 6
`define DRT_TM_WTR 7
`define DRT_TM_N 8

`endif

// ===== hw/drt_pkg.sv
// Shared types of the refresh and command-timing block
package drt_pkg;
  // SDRAM command codes on the sequencer bus
  typedef enum logic [3:0] {
    DRT_NOP = 4'h0,
    DRT_ACT = 4'h1,
    DRT_RD = 4'h2,
    DRT_WR = 4'h3,
    DRT_PRE = 4'h4,
    DRT_REF = 4'h5,
    DRT_LM = 4'h6,
    DRT_SRE = 4'h7,
    DRT_SRX = 4'h8
  } drt_cmd_t;

  // One command with its target bank
  typedef struct packed {
    logic valid;
    drt_cmd_t cmd;
    logic [2:0] bank;
  } drt_cmd_bus_t;

  // Self-refresh sequencing states
  typedef enum logic [3:0] {
    SLF_RUN = 4'b0001,
    SLF_ENTER = 4'b0010,
    SLF_HOLD = 4'b0100,
    SLF_EXIT = 4'b1000
  } drt_slf_state_t;

  // Spacing counter and refresh interval widths
  typedef logic [6:0] drt_cnt_t;
  typedef logic [15:0] drt_ivl_t;
endpackage : drt_pkg

// ===== hw/drt_edge_sync.sv
// Two-flop synchroniser and rising-edge finder for the DDR clock input
`timescale 1ns/1ps
module drt_edge_sync (
  input logic clk, // Block clock
  input logic rst, // Synchronous reset
  input logic level_in, // Foreign-domain level
  output logic rise // One-cycle pulse per rising edge
);
  logic meta_r, meta_nxt; // First stage, read only by the second
  logic sync_r, sync_nxt; // Second stage
  logic prev_r, prev_nxt; // Delayed copy for edge finding
  logic rise_r, rise_nxt; // Registered edge pulse

  // Next values
  always_comb begin
    meta_nxt = level_in;
    sync_nxt = meta_r;
    prev_nxt = sync_r;
    rise_nxt = sync_r & ~prev_r;
  end

  // Registers only
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
      rise_r <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      prev_r <= prev_nxt;
      rise_r <= rise_nxt;
    end
  end

  assign rise = rise_r;
endmodule : drt_edge_sync

// ===== hw/drt_gap_timer.sv
// Down-counter that holds off one dependent command for a number of DDR clocks
`timescale 1ns/1ps
module drt_gap_timer
  import drt_pkg::*;
(
  input logic clk, // Block clock
  input logic rst, // Synchronous reset
  input logic tick, // One pulse per DDR clock
  input logic load, // Triggering command issues
  input drt_cnt_t load_val, // Spacing field value
  output logic expired // Dependent command may go
);
  drt_cnt_t cnt_r, cnt_nxt; // Remaining DDR clocks

  // Load on the trigger, count down on DDR clocks
  always_comb begin
    cnt_nxt = cnt_r;
    if (load) begin
      cnt_nxt = load_val;
    end else if (tick && cnt_r != '0) begin
      cnt_nxt = cnt_r - drt_cnt_t'(1);
    end
  end

  // Registers only
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Zero means the field's count of DDR clocks has passed; the dependent command goes on the next one
  assign expired = (cnt_r == '0);

  property p_hold_after_load;
    @(posedge clk) disable iff (rst)
    (load && load_val != '0) |=> !expired;
  endproperty
  a_hold_after_load: assert property (p_hold_after_load)
    else $error("Spacing timer expired right after a nonzero load");
endmodule : drt_gap_timer

// ===== hw/drt_refresh_timing.sv
// Refresh, self-refresh and command-spacing control with its Wishbone registers
`timescale 1ns/1ps
`include "drt_map.svh"

module drt_refresh_timing
  import drt_pkg::*;
(
  input logic REF_CLK, // Block clock, 200 MHz
  input logic RST, // Synchronous reset, active high
  input logic WB_CYC_I, // Wishbone cycle
  input logic WB_STB_I, // Wishbone strobe
  input logic WB_WE_I, // Wishbone write
  input logic [`DRT_ADR_W-1:0] WB_ADR_I, // Wishbone byte address
  input logic [3:0] WB_SEL_I, // Wishbone byte enables
  input logic [31:0] WB_DAT_I, // Wishbone write data
  output logic [31:0] WB_DAT_O, // Wishbone read data
  output logic WB_ACK_O, // Wishbone acknowledge
  input logic DDR_CLK, // DDR clock, sampled here
  input drt_cmd_bus_t CMD_REQ, // Sequencer command, held until acked
  output logic CMD_ACK, // Pulse: requested command issued
  output drt_cmd_bus_t MEM_CMD, // Command toward memory
  output logic MEM_CLK_RUN, // High keeps memory clock running
  output logic INIT_START // Pulse: start initialization
);
  // Byte-lane merge of a write into a register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] din,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = din[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // Whether a sequencer command may issue now
  function automatic logic cmd_ok(input drt_cmd_t c, input logic [`DRT_TM_N-1:0] d);
    case (c)
      DRT_ACT: return d[`DRT_TM_RFC] & d[`DRT_TM_RP] & d[`DRT_TM_RC] & d[`DRT_TM_RRD];
      DRT_RD: return d[`DRT_TM_RCD] & d[`DRT_TM_WTR];
      DRT_WR: return d[`DRT_TM_RCD];
      DRT_PRE: return d[`DRT_TM_RAS] & d[`DRT_TM_WR];
      DRT_LM: return d[`DRT_TM_RP];
      default: return 1'b0; // Refresh and self-refresh are ours alone
    endcase
  endfunction : cmd_ok

  logic tick; // One pulse per DDR clock rising edge
  logic wb_req; // Request present
  logic wr_en; // Write takes effect this edge
  logic ack_r, ack_nxt; // Bus acknowledge
  logic [31:0] dat_r, dat_nxt; // Bus read data
  logic [31:0] bankcfg_r, bankcfg_nxt; // Bank configuration (unlock bit only)
  logic [31:0] refctl_r, refctl_nxt; // Refresh control
  logic [31:0] timing_r, timing_nxt; // Command timing
  logic [31:0] rc_merge, tm_merge; // Merged write values
  logic [31:0] status; // Read-only status word
  logic ivl_small; // Interval written below the floor
  drt_ivl_t ivl_twice; // Twice the refresh-cycle field
  logic tm_wr; // Accepted timing write
  logic init_r, init_nxt; // Initialization start pulse
  drt_ivl_t ivl_cnt_r, ivl_cnt_nxt; // Refresh interval counter
  logic expire; // Interval elapsed this tick
  logic ref_pend_r, ref_pend_nxt; // Auto-refresh pending
  drt_slf_state_t slf_r, slf_nxt; // Self-refresh sequencer
  drt_cmd_bus_t issue; // Command chosen this cycle
  drt_cmd_bus_t mem_cmd_r; // Registered command out
  logic ack_cmd_r, ack_cmd_nxt; // Sequencer acknowledge
  logic clk_run_r, clk_run_nxt; // Memory clock run
  logic [`DRT_TM_N-1:0] tm_load; // Timer triggers
  logic [`DRT_TM_N-1:0] tm_done; // Timer expiries
  drt_cnt_t tm_val [`DRT_TM_N]; // Timer load values

  // DDR clock crosses in through two flops, then edges become ticks
  drt_edge_sync u_sync (
    .clk(REF_CLK),
    .rst(RST),
    .level_in(DDR_CLK),
    .rise(tick)
  );

  // Bus slave: ack one cycle after the request, dropped the cycle after
  always_comb begin
    wb_req = WB_CYC_I & WB_STB_I;
    ack_nxt = wb_req & ~ack_r;
    dat_nxt = dat_r;
    status = '0;
    status[`DRT_ST_INSR_B] = (slf_r == SLF_HOLD);
    status[`DRT_ST_CLKRUN_B] = clk_run_r;
    status[`DRT_ST_REFPEND_B] = ref_pend_r;
    if (wb_req && !ack_r && !WB_WE_I) begin
      case (WB_ADR_I)
        `DRT_OFS_BANKCFG: dat_nxt = bankcfg_r;
        `DRT_OFS_REFCTL: dat_nxt = refctl_r;
        `DRT_OFS_TIMING: dat_nxt = timing_r;
        `DRT_OFS_STATUS: dat_nxt = status;
        default: dat_nxt = '0; // Unmapped reads return zero
      endcase
    end
  end

  // Register writes land on the edge that carries the ack
  always_comb begin
    wr_en = wb_req & ack_r & WB_WE_I;
    rc_merge = merge(refctl_r, WB_DAT_I, WB_SEL_I) & `DRT_REFCTL_MASK;
    tm_merge = merge(timing_r, WB_DAT_I, WB_SEL_I) & `DRT_TIMING_MASK;
    ivl_small = rc_merge[`DRT_IVL_F] < `DRT_IVL_MIN;
    ivl_twice = drt_ivl_t'({timing_r[`DRT_TRFC_F], 1'b0});
    bankcfg_nxt = bankcfg_r;
    refctl_nxt = refctl_r;
    timing_nxt = timing_r;
    if (wr_en && WB_ADR_I == `DRT_OFS_BANKCFG) begin
      bankcfg_nxt = merge(bankcfg_r, WB_DAT_I, WB_SEL_I) & `DRT_BANKCFG_MASK;
    end
    if (wr_en && WB_ADR_I == `DRT_OFS_REFCTL) begin
      refctl_nxt = rc_merge;
      if (ivl_small) begin
        refctl_nxt[`DRT_IVL_F] = ivl_twice;
      end
    end
    // Locked writes are acked but leave the fields alone
    tm_wr = wr_en && WB_ADR_I == `DRT_OFS_TIMING && bankcfg_r[`DRT_UNLOCK_B];
    if (tm_wr) begin
      timing_nxt = tm_merge;
    end
    init_nxt = tm_wr && tm_merge[`DRT_TWR_F] != timing_r[`DRT_TWR_F];
  end

  // Refresh interval counter in DDR clocks
  always_comb begin
    ivl_cnt_nxt = ivl_cnt_r;
    expire = 1'b0;
    if (tick) begin
      if (ivl_cnt_r <= drt_ivl_t'(1)) begin
        ivl_cnt_nxt = refctl_r[`DRT_IVL_F];
        expire = 1'b1;
      end else begin
        ivl_cnt_nxt = ivl_cnt_r - drt_ivl_t'(1);
      end
    end
  end

  // Self-refresh sequencing and command choice, one command per DDR clock
  always_comb begin
    slf_nxt = slf_r;
    issue = '0;
    ack_cmd_nxt = 1'b0;
    case (slf_r)
      SLF_RUN: begin
        if (refctl_r[`DRT_SRREQ_B]) begin
          slf_nxt = SLF_ENTER;
        end else if (tick && ref_pend_r && tm_done[`DRT_TM_RFC] && tm_done[`DRT_TM_RP]) begin
          issue.valid = 1'b1;
          issue.cmd = DRT_REF;
        end else if (tick && CMD_REQ.valid && !ack_cmd_r && cmd_ok(CMD_REQ.cmd, tm_done)) begin
          issue = CMD_REQ;
          ack_cmd_nxt = 1'b1;
        end
      end
      SLF_ENTER: begin
        // Entry waits out refresh and precharge spacing
        if (!refctl_r[`DRT_SRREQ_B]) begin
          slf_nxt = SLF_RUN;
        end else if (tick && tm_done[`DRT_TM_RFC] && tm_done[`DRT_TM_RP]) begin
          issue.valid = 1'b1;
          issue.cmd = DRT_SRE;
          slf_nxt = SLF_HOLD;
        end
      end
      SLF_HOLD: begin
        if (!refctl_r[`DRT_SRREQ_B]) begin
          slf_nxt = SLF_EXIT;
        end
      end
      SLF_EXIT: begin
        // Clock already runs again here, so ticks keep coming
        if (tick) begin
          issue.valid = 1'b1;
          issue.cmd = DRT_SRX;
          slf_nxt = SLF_RUN;
        end
      end
      default: slf_nxt = SLF_RUN;
    endcase
    // Clock stops only inside self-refresh and only when allowed
    clk_run_nxt = !(slf_nxt == SLF_HOLD && refctl_r[`DRT_CLKSTOP_B]);
    // A new expiry beats the refresh that clears the old one
    ref_pend_nxt = expire | (ref_pend_r & !(issue.valid && issue.cmd == DRT_REF));
  end

  // Spacing timer triggers and loads
  always_comb begin
    tm_load = '0;
    if (issue.valid) begin
      tm_load[`DRT_TM_RFC] = issue.cmd == DRT_REF || issue.cmd == DRT_LM;
      tm_load[`DRT_TM_RP] = issue.cmd == DRT_PRE;
      tm_load[`DRT_TM_RCD] = issue.cmd == DRT_ACT;
      tm_load[`DRT_TM_WR] = issue.cmd == DRT_WR;
      tm_load[`DRT_TM_RAS] = issue.cmd == DRT_ACT;
      tm_load[`DRT_TM_RC] = issue.cmd == DRT_ACT;
      tm_load[`DRT_TM_RRD] = issue.cmd == DRT_ACT;
      tm_load[`DRT_TM_WTR] = issue.cmd == DRT_WR;
    end
    tm_val[`DRT_TM_RFC] = drt_cnt_t'(timing_r[`DRT_TRFC_F]);
    tm_val[`DRT_TM_RP] = drt_cnt_t'(timing_r[`DRT_TRP_F]);
    tm_val[`DRT_TM_RCD] = drt_cnt_t'(timing_r[`DRT_TRCD_F]);
    tm_val[`DRT_TM_WR] = drt_cnt_t'(timing_r[`DRT_TWR_F]);
    tm_val[`DRT_TM_RAS] = drt_cnt_t'(timing_r[`DRT_TRAS_F]);
    tm_val[`DRT_TM_RC] = drt_cnt_t'(timing_r[`DRT_TRC_F]);
    tm_val[`DRT_TM_RRD] = drt_cnt_t'(timing_r[`DRT_TRRD_F]);
    tm_val[`DRT_TM_WTR] = drt_cnt_t'(timing_r[`DRT_TWTR_F]);
  end

  // One down-counter per constraint
  for (genvar i = 0; i < `DRT_TM_N; i++) begin : g_tm
    drt_gap_timer u_tm (
      .clk(REF_CLK),
      .rst(RST),
      .tick(tick),
      .load(tm_load[i]),
      .load_val(tm_val[i]),
      .expired(tm_done[i])
    );
  end

  // State registers, apart from the checking aid and the spacing timers
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ack_r <= 1'b0;
      dat_r <= '0;
      bankcfg_r <= `DRT_BANKCFG_RST;
      refctl_r <= `DRT_REFCTL_RST;
      timing_r <= `DRT_TIMING_RST;
      init_r <= 1'b0;
      ivl_cnt_r <= drt_ivl_t'(`DRT_REFCTL_RST);
      ref_pend_r <= 1'b0;
      slf_r <= SLF_RUN;
      mem_cmd_r <= '0;
      ack_cmd_r <= 1'b0;
      clk_run_r <= 1'b1;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      bankcfg_r <= bankcfg_nxt;
      refctl_r <= refctl_nxt;
      timing_r <= timing_nxt;
      init_r <= init_nxt;
      ivl_cnt_r <= ivl_cnt_nxt;
      ref_pend_r <= ref_pend_nxt;
      slf_r <= slf_nxt;
      mem_cmd_r <= issue;
      ack_cmd_r <= ack_cmd_nxt;
      clk_run_r <= clk_run_nxt;
    end
  end

  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = dat_r;
  assign CMD_ACK = ack_cmd_r;
  assign MEM_CMD = mem_cmd_r;
  assign MEM_CLK_RUN = clk_run_r;
  assign INIT_START = init_r;

  // Checking aid: DDR clocks since the last refresh/load-mode and since the last activate
  drt_cnt_t gap_ref_r, gap_ref_nxt, gap_act_r, gap_act_nxt;
  always_comb begin
    gap_ref_nxt = gap_ref_r;
    gap_act_nxt = gap_act_r;
    if (tm_load[`DRT_TM_RFC]) begin
      gap_ref_nxt = '0;
    end else if (tick && gap_ref_r != '1) begin
      gap_ref_nxt = gap_ref_r + drt_cnt_t'(1);
    end
    if (tm_load[`DRT_TM_RC]) begin
      gap_act_nxt = '0;
    end else if (tick && gap_act_r != '1) begin
      gap_act_nxt = gap_act_r + drt_cnt_t'(1);
    end
  end
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      gap_ref_r <= '1;
      gap_act_r <= '1;
    end else begin
      gap_ref_r <= gap_ref_nxt;
      gap_act_r <= gap_act_nxt;
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  sequence s_exit_asked;
    slf_r == SLF_HOLD && !refctl_r[`DRT_SRREQ_B];
  endsequence
  sequence s_exit_issued;
    slf_r == SLF_EXIT ##[1:400] (MEM_CMD.valid && MEM_CMD.cmd == DRT_SRX);
  endsequence
  property p_slf_exit;
    s_exit_asked |=> s_exit_issued;
  endproperty
  a_slf_exit: assert property (p_slf_exit)
    else $error("Self-refresh exit not issued after request cleared");

  property p_clk_runs;
    !refctl_r[`DRT_CLKSTOP_B] |=> MEM_CLK_RUN;
  endproperty
  a_clk_runs: assert property (p_clk_runs)
    else $error("Memory clock stopped without clock stop enable");

  property p_ivl_floor;
    (wr_en && WB_ADR_I == `DRT_OFS_REFCTL && ivl_small)
      |=> refctl_r[`DRT_IVL_F] == $past(ivl_twice);
  endproperty
  a_ivl_floor: assert property (p_ivl_floor)
    else $error("Small refresh interval not replaced by twice refresh-cycle");

  property p_locked;
    (wr_en && WB_ADR_I == `DRT_OFS_TIMING && !bankcfg_r[`DRT_UNLOCK_B]) |=> $stable(timing_r);
  endproperty
  a_locked: assert property (p_locked)
    else $error("Timing register changed while locked");

  property p_rfc_gap;
    (issue.valid && (issue.cmd == DRT_ACT || issue.cmd == DRT_REF))
      |-> gap_ref_r >= drt_cnt_t'(timing_r[`DRT_TRFC_F]);
  endproperty
  a_rfc_gap: assert property (p_rfc_gap)
    else $error("Refresh-cycle spacing violated");

  property p_rcd_gap;
    (issue.valid && (issue.cmd == DRT_RD || issue.cmd == DRT_WR))
      |-> gap_act_r >= drt_cnt_t'(timing_r[`DRT_TRCD_F]);
  endproperty
  a_rcd_gap: assert property (p_rcd_gap)
    else $error("Activate-to-access spacing violated");

  property p_init;
    init_nxt |=> INIT_START ##1 !INIT_START;
  endproperty
  a_init: assert property (p_init)
    else $error("Initialization start not a single pulse after write-recovery change");

  property p_ras_gap;
    (issue.valid && issue.cmd == DRT_PRE) |-> gap_act_r >= drt_cnt_t'(timing_r[`DRT_TRAS_F]);
  endproperty
  a_ras_gap: assert property (p_ras_gap)
    else $error("Activate-to-precharge spacing violated");

  property p_rc_gap;
    (issue.valid && issue.cmd == DRT_ACT) |-> gap_act_r >= drt_cnt_t'(timing_r[`DRT_TRC_F]);
  endproperty
  a_rc_gap: assert property (p_rc_gap)
    else $error("Activate-to-activate spacing violated");

  property p_ref_post;
    expire |=> ref_pend_r;
  endproperty
  a_ref_post: assert property (p_ref_post)
    else $error("Interval expiry did not post a refresh");
endmodule : drt_refresh_timing

// ===== dv/drt_mem_model.sv
// Memory-side model: makes the DDR clock and times issued commands
`timescale 1ns/1ps
module drt_mem_model
  import drt_pkg::*;
(
  input logic clk, // Block clock
  input logic clk_run, // Memory clock allowed to run
  input logic hold, // Bench pause of the clock
  input drt_cmd_bus_t mem_cmd, // Issued command
  output logic ddr_clk, // DDR clock, 64 ns period
  output int gap // DDR clocks since previous command
);
  int edges; // DDR rising edges seen
  int mark; // Edge count at last command

  initial begin
    ddr_clk = 1'b0;
    edges = 0;
    mark = 0;
    gap = 0;
  end

  // Clock stands still while stopped, as a stopped memory clock would
  always begin
    #32;
    if (clk_run && !hold) ddr_clk = ~ddr_clk;
  end

  // Edge count, so spacing is judged in DDR clocks
  always @(posedge ddr_clk) edges <= edges + 1;

  // Gap taken at each command pulse; tick delay is constant so it cancels
  always @(posedge clk) begin
    if (mem_cmd.valid === 1'b1) begin
      gap <= edges - mark;
      mark <= edges;
    end
  end
endmodule : drt_mem_model

// ===== dv/drt_refresh_timing_tb_top.sv
// Self-checking bench of the refresh and command-timing block
`timescale 1ns/1ps
`include "drt_map.svh"
`define CHK(a, e) begin \
  cmp_count++; \
  if ((a) !== (e)) begin \
    failures++; \
    $display("wrong value at %0t: got %h, expected %h", $time, (a), (e)); \
  end \
end
module drt_refresh_timing_tb_top
  import drt_pkg::*;
;
  // Small legal timing set: rfc 2 rp 1 rcd 3 wr 2 ras 4 rc 5 rrd 1 wtr 1
  localparam logic [31:0] TIM = 32'h045a2149;
  logic REF_CLK, RST, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O;
  logic [7:0] WB_ADR_I; // Byte address
  logic [3:0] WB_SEL_I; // Byte lanes
  logic [31:0] WB_DAT_I, WB_DAT_O; // Bus data
  logic DDR_CLK, CMD_ACK, MEM_CLK_RUN, INIT_START; // Link side
  drt_cmd_bus_t CMD_REQ, MEM_CMD; // Command carriers
  logic hold; // Pauses the memory clock
  int gap, failures, cmp_count, init_cnt; // Gap, tallies, init pulses

  drt_refresh_timing i_dut (.REF_CLK(REF_CLK), .RST(RST), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
    .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .DDR_CLK(DDR_CLK),
    .CMD_REQ(CMD_REQ), .CMD_ACK(CMD_ACK), .MEM_CMD(MEM_CMD), .MEM_CLK_RUN(MEM_CLK_RUN),
    .INIT_START(INIT_START));

  drt_mem_model i_mem (.clk(REF_CLK), .clk_run(MEM_CLK_RUN), .hold(hold),
    .mem_cmd(MEM_CMD), .ddr_clk(DDR_CLK), .gap(gap));

  // 200 MHz block clock
  always #2.5 REF_CLK = ~REF_CLK;

  // Init pulses counted, since they last one cycle
  always @(posedge REF_CLK) begin
    if (INIT_START === 1'b1) init_cnt++;
  end

  // Verdict and end of run
  task automatic end_of_test();
    if (failures == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  // One classic cycle; waits for ack, takes data at that edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge REF_CLK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= a;
    WB_SEL_I <= 4'hf;
    WB_DAT_I <= d;
    // No limit of its own: only the watchdog ends a hung bus wait
    do begin
      @(posedge REF_CLK);
    end while (WB_ACK_O !== 1'b1);
    q = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    `CHK(WB_ACK_O, 1'b1)
  endtask : wb

  // Read and compare
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    `CHK(q, e)
  endtask : rd

  // Write, reply ignored
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  // Waits for a given command on the memory side
  task automatic wait_cmd(input drt_cmd_t c);
    int n;
    for (n = 0; n < 20000; n++) begin
      @(posedge REF_CLK);
      if (MEM_CMD.valid === 1'b1 && MEM_CMD.cmd === c) break;
    end
    `CHK(MEM_CMD.cmd, c)
  endtask : wait_cmd

  // Requests a command held until ack; g is the expected DDR clock gap
  task automatic issue(input drt_cmd_t c, input logic [2:0] b, input int g);
    int n;
    @(posedge REF_CLK);
    CMD_REQ <= '{1'b1, c, b};
    for (n = 0; n < 2000; n++) begin
      @(posedge REF_CLK);
      if (CMD_ACK === 1'b1) break;
    end
    CMD_REQ <= '0;
    `CHK(MEM_CMD.cmd, c)
    `CHK(MEM_CMD.bank, b)
    @(negedge REF_CLK);
    if (g > 0) `CHK(gap, g)
  endtask : issue

  // Reset values and an unmapped place
  task automatic t_reset_vals();
    rd(`DRT_OFS_BANKCFG, `DRT_BANKCFG_RST);
    rd(`DRT_OFS_REFCTL, `DRT_REFCTL_RST);
    rd(`DRT_OFS_TIMING, `DRT_TIMING_RST);
    rd(8'h10, 32'h0);
  endtask : t_reset_vals

  // Locked write ignored, unlocked write lands and starts init once
  task automatic t_lock();
    wr(`DRT_OFS_TIMING, TIM);
    rd(`DRT_OFS_TIMING, `DRT_TIMING_RST);
    `CHK(init_cnt, 0)
    wr(`DRT_OFS_BANKCFG, 32'h00008000);
    wr(`DRT_OFS_TIMING, TIM);
    rd(`DRT_OFS_TIMING, TIM);
    `CHK(init_cnt, 1)
    wr(`DRT_OFS_TIMING, TIM);
    `CHK(init_cnt, 1)
  endtask : t_lock

  // Back-to-back commands must go at the minimum spacing, no later
  task automatic t_spacing();
    wr(`DRT_OFS_REFCTL, 32'h0000ffff);
    issue(DRT_ACT, 3'h0, 0);
    issue(DRT_WR, 3'h0, 4);
    issue(DRT_RD, 3'h0, 2);
    issue(DRT_PRE, 3'h0, 1);
    issue(DRT_ACT, 3'h0, 2);
    issue(DRT_ACT, 3'h1, 6);
    issue(DRT_PRE, 3'h1, 5);
    issue(DRT_LM, 3'h0, 2);
    issue(DRT_ACT, 3'h0, 3);
    issue(DRT_WR, 3'h0, 4);
    issue(DRT_PRE, 3'h0, 3);
  endtask : t_spacing

  // Interval floor, then refresh period measured in DDR clocks
  task automatic t_refresh();
    wr(`DRT_OFS_REFCTL, 32'h000000ff);
    rd(`DRT_OFS_REFCTL, 32'h00000004);
    wr(`DRT_OFS_REFCTL, 32'h00000100);
    rd(`DRT_OFS_REFCTL, 32'h00000100);
    wait_cmd(DRT_REF);
    wait_cmd(DRT_REF);
    @(negedge REF_CLK);
    `CHK(gap, 256)
    wait_cmd(DRT_REF);
    @(negedge REF_CLK);
    `CHK(gap, 256)
    wr(`DRT_OFS_REFCTL, 32'h0000ffff);
  endtask : t_refresh

  // Self-refresh without and with clock stop
  task automatic t_self_refresh();
    wr(`DRT_OFS_REFCTL, 32'h8000ffff);
    wait_cmd(DRT_SRE);
    repeat (30) @(posedge REF_CLK);
    `CHK(MEM_CLK_RUN, 1'b1)
    rd(`DRT_OFS_STATUS, 32'h00000003);
    wr(`DRT_OFS_REFCTL, 32'h0000ffff);
    wait_cmd(DRT_SRX);
    // Clock paused so both writes land before entry is attempted
    hold <= 1'b1;
    wr(`DRT_OFS_REFCTL, 32'h8000ffff);
    wr(`DRT_OFS_REFCTL, 32'hc000ffff);
    hold <= 1'b0;
    wait_cmd(DRT_SRE);
    @(negedge REF_CLK);
    `CHK(MEM_CLK_RUN, 1'b0)
    wr(`DRT_OFS_REFCTL, 32'h4000ffff);
    wait_cmd(DRT_SRX);
    `CHK(MEM_CLK_RUN, 1'b1)
  endtask : t_self_refresh

  // Main sequence; each scenario judges its own outcome
  initial begin
    REF_CLK = 1'b0;
    RST = 1'b1;
    WB_CYC_I = 1'b0;
    WB_STB_I = 1'b0;
    WB_WE_I = 1'b0;
    WB_ADR_I = 8'h00;
    WB_SEL_I = 4'h0;
    WB_DAT_I = 32'h0;
    CMD_REQ = '0;
    hold = 1'b0;
    failures = 0;
    cmp_count = 0;
    init_cnt = 0;
    repeat (2) @(posedge REF_CLK);
    RST <= 1'b0;
    t_reset_vals();
    t_lock();
    t_spacing();
    t_refresh();
    t_self_refresh();
    end_of_test();
  end

  // Watchdog well beyond the expected run of about 100 us
  initial begin
    #400000;
    failures++;
    end_of_test();
  end
endmodule : drt_refresh_timing_tb_top
